// file: design/ssl_fifo.sv
/*
  Small synchronous FIFO holding shift chain snapshots on their way to the storage register.
  Assumes mclk/rst from the core and a clock enable that freezes all state.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ssl_regs.svh"

module ssl_fifo #(
  parameter int WIDTH = `SSL_WIDTH,
  parameter int DEPTH = `SSL_FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // data sides
  ssl_fifo_if.fifo f
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;
  logic             push;
  logic             pop;

  // honest flags straight from the occupancy count
  assign f.in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign f.out_valid = (cnt_q != '0);
  assign f.out_data  = mem_q[rd_q];
  assign push        = ce & f.in_valid & f.in_ready;
  assign pop         = ce & f.out_valid & f.out_ready;

  // storage words
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= f.in_data;
    end
  end

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

`default_nettype wire

// file: design/ssl_fifo_if.sv
/*
  Valid/ready carrier between the shift latch core and its snapshot FIFO.
  Assumes one clock domain on both sides.
*/
`timescale 1ns/10ps
`default_nettype none

interface ssl_fifo_if;
  logic              in_valid;
  logic              in_ready;
  ssl_pkg::ssl_byte_t in_data;
  logic              out_valid;
  logic              out_ready;
  ssl_pkg::ssl_byte_t out_data;

  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

`default_nettype wire

// file: design/ssl_pkg.sv
/*
  Types shared by the shift latch modules.
  Assumes ssl_regs.svh is on the include path.
*/
`include "ssl_regs.svh"

package ssl_pkg;
  typedef logic [`SSL_WIDTH-1:0] ssl_byte_t;
  typedef logic [`SSL_PTR_W-1:0] ssl_ptr_t;
endpackage

// file: design/ssl_regs.svh
/*
  Constants of the serial-in, parallel-out shift latch: widths, depths and reset values.
  Assumes inclusion by bare name from design files; holds definitions only.
*/
`ifndef SSL_REGS_SVH
`define SSL_REGS_SVH

// ==========================================================================
// structure
`define SSL_WIDTH        8
`define SSL_FIFO_DEPTH   4
`define SSL_PTR_W        2

// ==========================================================================
// reset values
`define SSL_CHAIN_RST    8'h00
`define SSL_STORE_RST    8'h00
`define SSL_OE_N_RST     8'hff
`define SSL_SYNC_RST     5'h05   // idle pins: clocks low, clear and enable inactive

`endif

// file: design/ssl_top.sv
/*
  Serial-in, parallel-out shift chain with a storage register and floating parallel outputs.
  Pins are synchronised, clock edges found by oversampling, and snapshots queued to storage.
  Assumes every pin input is asynchronous to mclk (40 MHz) and slow enough to be oversampled;
  the shift and storage clocks are sampled as data and their rising edges detected.
  Each clock pin must stay high and low for more than one mclk period, or an edge is lost.
  The pins reach the logic two mclk edges late, so even the clear is not instantaneous.
  While ce is low nothing moves, not even the synchronisers; pin activity then is missed.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ssl_regs.svh"

// Behaviour
// - eight stage serial chain whose contents transfer into a separate storage register
// - storage bits appear on parallel outputs that can drive high, low or float
// - enable high floats parallel outputs, low drives them; cascade always driven
// - shift chain and storage register have independent clocks
// - clear low zeroes the chain at once, overriding the shift clock; here on the third mclk edge after the pin falls
// - shift clock rise loads serial input into stage one, others take predecessor
// - shift clock fall leaves the chain unchanged
// - storage clock rise copies all eight chain stages into storage in parallel
// - storage clock fall leaves storage unchanged
// - clocks tied: storage takes chain as before the edge, one pulse behind
// - serial output from the last stage allows cascading devices
module ssl_top (
  // clock, reset, enable
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // controller pins
  input  wire logic                 serial_in,
  input  wire logic                 shift_clock,
  input  wire logic                 shift_clear_n,
  input  wire logic                 storage_clock,
  input  wire logic                 output_enable_n,
  // device pins
  output logic [`SSL_WIDTH-1:0]     parallel_out,
  output logic [`SSL_WIDTH-1:0]     parallel_out_oe_n,
  output logic                      cascade_out
);
  // ==========================================================================
  // pin synchronisers
  // bit order in every stage: serial, shift clock, clear_n, storage clock, enable_n
  logic [4:0]          sync1_q;
  logic [4:0]          sync2_q;
  logic                sclk3_q;
  logic                rclk3_q;
  logic                shift_rise;
  logic                store_rise;
  logic                clear_act;
  ssl_pkg::ssl_byte_t  chain_q;
  ssl_pkg::ssl_byte_t  store_q;
  logic                store_hold;
  ssl_fifo_if          fq ();

  // shifted chain, taken only on a qualified rise
  ssl_pkg::ssl_byte_t  chain_d;

  // reset image of the chain, read bit by bit by the stage loop
  localparam ssl_pkg::ssl_byte_t CHAIN_RST = `SSL_CHAIN_RST;

  // rising edge of a sampled clock; second stage against its delayed copy
  function automatic logic rise(input logic now_v, input logic old_v);
    rise = now_v & ~old_v;
  endfunction

  // first stage feeds only the second; logic reads from stage two onward
  // two flops cost two cycles of latency but keep metastability away from the chain
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_q <= `SSL_SYNC_RST;
      sync2_q <= `SSL_SYNC_RST;
      sclk3_q <= 1'b0;
      rclk3_q <= 1'b0;
    end else if (ce) begin
      sync1_q <= {serial_in, shift_clock, shift_clear_n, storage_clock, output_enable_n};
      sync2_q <= sync1_q;
      sclk3_q <= sync2_q[3];
      rclk3_q <= sync2_q[1];
    end
  end

  // separate edge detectors keep the two clocks independent
  // reset matches the idle pins, so no false edge or false clear follows reset
  assign shift_rise = rise(sync2_q[3], sclk3_q);
  assign store_rise = rise(sync2_q[1], rclk3_q);
  assign clear_act  = ~sync2_q[2];
  // a full snapshot FIFO stalls shifting; a snapshot offered while it is full is dropped
  assign store_hold = ~fq.in_ready;

  // ==========================================================================
  // shift chain
  // next chain value of a shift: the serial level enters stage one
  assign chain_d = {chain_q[`SSL_WIDTH-2:0], sync2_q[4]};

  // clear wins over any edge; falling edges simply find no rise
  genvar gi;
  generate
    for (gi = 0; gi < `SSL_WIDTH; gi++) begin : g_stage
      always_ff @(posedge mclk) begin
        if (rst) begin
          chain_q[gi] <= CHAIN_RST[gi];
        end else if (ce) begin
          if (clear_act) begin
            chain_q[gi] <= 1'b0;
          end else if (shift_rise && !store_hold) begin
            chain_q[gi] <= chain_d[gi];
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // snapshot path: the pre-edge chain goes in, so tied clocks lag one pulse
  // the queue decouples the storage write from the edge detector at one cycle of cost
  assign fq.in_valid  = store_rise;
  assign fq.in_data   = chain_q;
  assign fq.out_ready = 1'b1;

  ssl_fifo #(
    .WIDTH (`SSL_WIDTH),
    .DEPTH (`SSL_FIFO_DEPTH)
  ) u_fifo (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .f    (fq.fifo)
  );

  // storage register takes snapshots only; the clear never reaches it
  // a queued word lands one edge after its push
  always_ff @(posedge mclk) begin
    if (rst) begin
      store_q <= `SSL_STORE_RST;
    end else if (ce && fq.out_valid) begin
      store_q <= fq.out_data;
    end
  end

  // ==========================================================================
  // output pins, all registered
  // registering costs a cycle but gives the pads clean levels
  always_ff @(posedge mclk) begin
    if (rst) begin
      parallel_out      <= `SSL_STORE_RST;
      parallel_out_oe_n <= `SSL_OE_N_RST;
      cascade_out       <= 1'b0;
    end else if (ce) begin
      parallel_out      <= store_q;
      parallel_out_oe_n <= {`SSL_WIDTH{sync2_q[0]}};
      cascade_out       <= chain_q[`SSL_WIDTH-1];
    end
  end

  // ==========================================================================
  // checks
  // all checks sample on mclk and rest while the synchronous reset is high
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // chain: clear, shift and hold
  a_clear_zero_chain: assert property (ce && clear_act |=> chain_q == 8'h00)
    else $error("chain not cleared");
  a_shift_load_in: assert property (ce && !clear_act && shift_rise && !store_hold
    |=> chain_q == {$past(chain_q[6:0]), $past(sync2_q[4])})
    else $error("shift did not move chain");
  a_no_edge_hold: assert property (ce && !clear_act && !shift_rise |=> $stable(chain_q))
    else $error("chain changed without rise");

  // each sampled rise acts once, however long the pin stays high
  a_shift_once: assert property (ce && shift_rise |=> !shift_rise)
    else $error("shift rise seen twice");
  a_store_once: assert property (ce && store_rise |=> !store_rise)
    else $error("storage rise seen twice");

  // the drain never stalls, so no shift edge and no snapshot is ever lost
  a_shift_no_stall: assert property (ce && shift_rise |-> !store_hold)
    else $error("shift edge stalled by full queue");
  a_snap_no_loss: assert property (ce && store_rise |-> fq.in_ready)
    else $error("snapshot refused by full queue");

  // storage: snapshot timing, word taken, hold
  a_store_path: assert property (ce && store_rise && fq.in_ready && !fq.out_valid
    |=> ##1 store_q == $past(chain_q, 2))
    else $error("storage missed snapshot");
  a_store_take: assert property (ce && fq.out_valid |=> store_q == $past(fq.out_data))
    else $error("storage took wrong word");
  a_store_hold: assert property (ce && !fq.out_valid |=> $stable(store_q))
    else $error("storage changed without transfer");

  // tied clocks: the queued word is the chain before the shift, not after it
  a_tied_pre_edge: assert property (ce && shift_rise && store_rise && !clear_act
    && !fq.out_valid |=> fq.out_data == $past(chain_q))
    else $error("tied clocks stored the shifted chain");

  // pins: enable, cascade and parallel data
  a_oe_follow: assert property (ce |=> parallel_out_oe_n == {8{$past(sync2_q[0])}})
    else $error("enable not followed");
  a_cascade_tail: assert property (ce |=> cascade_out == $past(chain_q[7]))
    else $error("cascade not last stage");
  a_cascade_clear: assert property (ce && clear_act ##1 ce |=> !cascade_out)
    else $error("cascade not cleared");
  a_cascade_quiet: assert property (ce && !shift_rise && !clear_act ##1 ce
    |=> $stable(cascade_out))
    else $error("cascade moved without shift or clear");
  a_pout_store: assert property (ce ##1 ce |=> parallel_out == $past(store_q))
    else $error("outputs not storage");
  a_pout_hold: assert property (ce ##1 ce && $stable(store_q) |=> $stable(parallel_out))
    else $error("outputs moved without transfer");

  // main scenarios: tied clocks, clear alone and over a shift, queue use, freeze
  c_tied_clocks: cover property (shift_rise && store_rise);
  c_clear_seen: cover property (clear_act ##1 !clear_act);
  c_clear_over_shift: cover property (clear_act && shift_rise);
  c_queue_used: cover property (fq.out_valid);
  c_ce_resume: cover property (!ce ##1 ce);
endmodule

`default_nettype wire

// file: sim/sipo_shift_latch_8bit_tb_top.sv
/*
  Self-checking bench for the shift latch top: the controller model drives the pins,
  expectations are queued and compared by a watcher. Assumes ce may stay high.
*/
`timescale 1ns/10ps
`default_nettype none

module sipo_shift_latch_8bit_tb_top;
  logic        mclk, rst, ce, obs, sd, sc, sclr_n, stc, oe_n, casc;
  logic [7:0]  po, po_oe_n, chain_e, store_e;
  logic        oe_e;
  logic [16:0] lfsr_q;
  logic [16:0] exp_q[$];
  int          miscompares = 0;
  int          n_compared = 0;

  ssl_ctrl_model i_ssl_ctrl_model (.mclk(mclk), .serial_in(sd), .shift_clock(sc),
    .shift_clear_n(sclr_n), .storage_clock(stc), .output_enable_n(oe_n));
  ssl_top i_ssl_top (.mclk(mclk), .rst(rst), .ce(ce), .serial_in(sd), .shift_clock(sc),
    .shift_clear_n(sclr_n), .storage_clock(stc), .output_enable_n(oe_n),
    .parallel_out(po), .parallel_out_oe_n(po_oe_n), .cascade_out(casc));

  // ==========================================================================
  // 40 MHz clock
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  function automatic logic [16:0] lfsr_next(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction

  task automatic check(input string what, input logic [16:0] exp, input logic [16:0] seen);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one link period with a random bit; expectations follow the pre-edge chain
  task automatic step(input logic sh, input logic st);
    logic d;
    d = lfsr_q[0];
    lfsr_q = lfsr_next(lfsr_q);
    if (st) store_e = chain_e;
    if (sh) chain_e = {chain_e[6:0], d};
    i_ssl_ctrl_model.pulse(sh, st, d);
  endtask

  // wait past the five-edge storage latency, then queue what the pins must show
  task automatic note();
    repeat (8) @(posedge mclk);
    exp_q.push_back({{8{oe_e}}, store_e, chain_e[7]});
    obs <= 1'b1;
    @(posedge mclk);
    obs <= 1'b0;
  endtask

  // watcher: the oldest note against the settled pins
  always @(posedge mclk) begin
    if (obs === 1'b1)
      check("pins", exp_q.pop_front(), {po_oe_n, po, casc});
  end

  // ==========================================================================
  // main sequence
  initial begin
    {rst, ce, obs, oe_e} = 4'b1101;
    {chain_e, store_e} = 16'h0000;
    lfsr_q = 17'h13e20;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    note();
    i_ssl_ctrl_model.oe(1'b0);
    oe_e = 1'b0;
    repeat (6) begin
      repeat (8) step(1'b1, 1'b0);
      step(1'b0, 1'b1);
      note();
    end
    $display("test shift_then_store done");
    repeat (4) begin
      step(1'b1, 1'b1);
      note();
    end
    $display("test tied_clocks done");
    i_ssl_ctrl_model.oe(1'b1);
    oe_e = 1'b1;
    step(1'b1, 1'b1);
    note();
    i_ssl_ctrl_model.oe(1'b0);
    oe_e = 1'b0;
    $display("test float_outputs done");
    i_ssl_ctrl_model.clear(1'b1);
    chain_e = 8'h00;
    note();
    step(1'b0, 1'b1);
    note();
    $display("test clear_override done");
    // a pulse while ce is low must leave chain, storage and pins untouched
    @(posedge mclk);
    ce <= 1'b0;
    i_ssl_ctrl_model.pulse(1'b1, 1'b1, 1'b1);
    @(posedge mclk);
    ce <= 1'b1;
    note();
    $display("test clock_enable_freeze done");
    stop_test();
  end

  // watchdog: the tests need well under 2000 mclk cycles
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    stop_test();
  end
endmodule

`default_nettype wire

// file: sim/ssl_ctrl_model.sv
/*
  Controller model: drives serial data, both clocks, clear and enable of the shift latch.
  Assumes mclk from the bench; pins change just after mclk rising edges.
*/
`timescale 1ns/10ps
`default_nettype none

module ssl_ctrl_model (
  // bench clock
  input  wire logic mclk,
  // pins toward the device
  output var logic  serial_in,
  output var logic  shift_clock,
  output var logic  shift_clear_n,
  output var logic  storage_clock,
  output var logic  output_enable_n
);
  // ==========================================================================
  // idle pins: clocks low, clear inactive, outputs floated
  initial {serial_in, shift_clock, shift_clear_n, storage_clock, output_enable_n} = 5'b00101;

  // one 200 ns link period; the clocks stand still between calls
  task automatic pulse(input logic sh, input logic st, input logic d);
    @(posedge mclk);
    serial_in <= d;
    repeat (3) @(posedge mclk);
    shift_clock <= sh;
    storage_clock <= st;
    repeat (4) @(posedge mclk);
    {shift_clock, storage_clock} <= 2'b00;
    serial_in <= ~d;                       // hold over: line stops showing the bit
  endtask

  // clear pulse, optionally with a shift edge that must be overridden
  task automatic clear(input logic sh);
    @(posedge mclk);
    shift_clear_n <= 1'b0;
    repeat (3) @(posedge mclk);
    shift_clock <= sh;
    repeat (4) @(posedge mclk);
    {shift_clock, shift_clear_n} <= 2'b01;
  endtask

  // enable pin level
  task automatic oe(input logic v);
    @(posedge mclk);
    output_enable_n <= v;
  endtask
endmodule

`default_nettype wire
